// >>> fws_bus_cycle.sv
// One asynchronous flash read or write cycle on the parallel pins
`timescale 1ns/1ps
module fws_bus_cycle import fws_pkg::*; #(
   parameter int AW = FL_ADDR_W,
   parameter int DW = FL_DATA_W
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   fws_cyc_if.engine cyc,
   output logic flash_ce_n_out,
   output logic flash_oe_n_out,
   output logic flash_we_n_out,
   output logic [AW-1:0] flash_addr_out,
   output logic [DW-1:0] flash_dq_out,
   output logic flash_dq_oe_out,
   input wire logic [DW-1:0] flash_dq_in
);
   typedef enum logic [1:0] {
      E_IDLE = 2'b00, E_SETUP = 2'b01, E_STROBE = 2'b10, E_END = 2'b11
   } fws_eng_type;
   typedef struct packed {
      fws_eng_type st;
      logic wr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [AW-1:0] addr;
      logic [DW-1:0] dout;
      logic doe;
      logic [DW-1:0] rdata;
      logic done;
   } fws_eng_state_type;
   fws_eng_state_type q_r, q_nxt;
   // ------------------------------------------------------------
   // Cycle sequencing
   // ------------------------------------------------------------
   // Between cycles a held poll keeps one strobe low so the other pulses
   always_comb begin
      q_nxt = q_r;
      q_nxt.done = 1'b0;
      unique case (q_r.st)
         E_IDLE: begin
            q_nxt.ce_n = ~(cyc.hold & ~cyc.strobe_ce); // see R2
            q_nxt.oe_n = ~(cyc.hold & cyc.strobe_ce); // see R2
            if (cyc.req) begin
               q_nxt.st = E_SETUP;
               q_nxt.wr = cyc.wr;
               q_nxt.addr = cyc.addr;
               q_nxt.dout = cyc.wdata;
               q_nxt.doe = cyc.wr;
               q_nxt.ce_n = 1'b0;
               q_nxt.oe_n = cyc.wr;
            end
         end
         E_SETUP: begin
            q_nxt.st = E_STROBE;
            q_nxt.we_n = ~q_r.wr;
         end
         E_STROBE: begin
            // Data has had two periods, well past the slowest access
            q_nxt.st = E_END;
            q_nxt.we_n = 1'b1;
            if (!q_r.wr) begin
               q_nxt.rdata = flash_dq_in;
            end
         end
         E_END: begin
            q_nxt.st = E_IDLE;
            q_nxt.done = 1'b1;
            q_nxt.doe = 1'b0;
            q_nxt.ce_n = ~(cyc.hold & ~cyc.strobe_ce);
            q_nxt.oe_n = ~(cyc.hold & cyc.strobe_ce);
         end
      endcase
   end
   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         q_r <= '{st: E_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  default: '0};
      end else begin
         q_r <= q_nxt;
      end
   end
   assign cyc.done = q_r.done;
   assign cyc.rdata = q_r.rdata;
   assign flash_ce_n_out = q_r.ce_n;
   assign flash_oe_n_out = q_r.oe_n;
   assign flash_we_n_out = q_r.we_n;
   assign flash_addr_out = q_r.addr;
   assign flash_dq_out = q_r.dout;
   assign flash_dq_oe_out = q_r.doe;
endmodule

// >>> fws_cyc_if.sv
// Bus cycle request and answer between sequencer and cycle engine
`timescale 1ns/1ps
interface fws_cyc_if #(parameter int AW = 23, parameter int DW = 16);
   logic req;
   logic wr;
   logic hold;
   logic strobe_ce;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic done;
   logic [DW-1:0] rdata;
   modport master (output req, wr, hold, strobe_ce, addr, wdata,
                   input done, rdata);
   modport engine (input req, wr, hold, strobe_ce, addr, wdata,
                   output done, rdata);
endinterface

// >>> fws_flash_model.sv
// Behavioural flash device answering the host strobes and status polls
`timescale 1ns/1ps
module fws_flash_model import fws_pkg::*; #(
   parameter int BUSY_CYC = 30,
   parameter logic [7:0] SUSP_SECT = 8'h05
) (
   input wire logic clk_in,
   input wire logic stuck_in,
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [22:0] addr_in,
   input wire logic [15:0] dq_in,
   input wire logic dq_oe_in,
   output logic [15:0] dq_out,
   output logic ready_busy_n_out
);
   logic [15:0] mem [0:255];
   logic [15:0] rd_r = 16'h0000;
   logic [15:0] tgt_r = 16'h0000;
   logic [7:0] prev_r = 8'h00;
   logic [22:0] last_a = 23'h0;
   logic rd_q = 1'b0;
   logic wr_q = 1'b0;
   logic tog_r = 1'b0;
   logic sus_r = 1'b0;
   logic pre_done = 1'b0;
   logic erasing = 1'b0;
   int busy_r = 0;
   int n_wr = 0;
   // A host that drives dq at the wrong time loses the cycle
   wire rd_act = !ce_n_in && !oe_n_in && !dq_oe_in;
   wire wr_act = !ce_n_in && !we_n_in && dq_oe_in;
   wire in_sus = addr_in[22:15] == SUSP_SECT;
   // Released lines show the inverse word so stale data never passes
   assign ready_busy_n_out = busy_r == 0 && !stuck_in;
   assign dq_out = rd_act ? rd_r : ~rd_r;
   // Strobes move only on host edges, so sampling there sees every one
   always @(posedge clk_in) begin
      rd_q <= rd_act;
      wr_q <= wr_act;
      if (busy_r > 0) begin
         busy_r <= busy_r - 1;
      end
      if (busy_r == 1 && erasing) begin
         erasing <= 1'b0;
         foreach (mem[i])
            mem[i] <= 16'hffff;
      end
      if (wr_act && !wr_q) begin
         n_wr <= n_wr + 1;
         last_a <= addr_in;
         prev_r <= dq_in[7:0];
         if (prev_r == CMD_PROGRAM) begin
            mem[addr_in[7:0]] <= dq_in;
            tgt_r <= dq_in;
            busy_r <= BUSY_CYC;
         end else if (dq_in[7:0] == CMD_SECTOR && prev_r == UNLOCK_DATA2) begin
            foreach (mem[i])
               mem[i] <= 16'h0000;
            pre_done <= 1'b1;
            erasing <= 1'b1;
            tgt_r <= 16'hffff;
            busy_r <= BUSY_CYC;
         end
      end
      if (rd_act && !rd_q) begin
         rd_r <= mem[addr_in[7:0]];
         if (busy_r > 0 || stuck_in) begin
            // Status word ignores the address for the busy toggle
            rd_r <= {8'h00, ~tgt_r[7], tog_r, 6'h00};
            tog_r <= ~tog_r;
         end else if (in_sus) begin
            rd_r[2] <= sus_r;
            sus_r <= ~sus_r;
         end
      end
   end
endmodule

// >>> fws_host.sv
// Host controller running program, erase, status polling and protection
// Operation
// R1: suspend toggle moves only in suspended sector
// R2: read strobe may be OE or CE
// R3: busy toggle needs no valid address
// R4: polling bit reads complement until done
// R5: protect: bit six low, one high, zero low
// R6: unprotect: bit six high, one high, zero low
// R7: erase preprograms target area to zero
// R8: program command is two or four writes
// R9: hold raised reset 4 us after ready
// R10: ready_busy_n falls within 90 ns
// R11: busy toggle inverts each read while busy
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module fws_host import fws_pkg::*; #(
   parameter int ADDR_W = FL_ADDR_W,
   parameter int DATA_W = FL_DATA_W,
   parameter int POLL_LIMIT = POLL_MAX_CYC
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out,
   output logic flash_ce_n_out,
   output logic flash_oe_n_out,
   output logic flash_we_n_out,
   output logic [ADDR_W-1:0] flash_addr_out,
   output logic [DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe_out,
   input wire logic [DATA_W-1:0] flash_dq_in,
   input wire logic ready_busy_n_in,
   output logic raised_pin_level_out
);
   localparam int CW = $clog2(POLL_LIMIT + 1);
   localparam int AD = ADDR_W + DATA_W;
   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_SEQ = 3'h1, S_SEQW = 3'h2, S_BUSY = 3'h3,
      S_POLL = 3'h4, S_POLLW = 3'h5, S_RAISE = 3'h6, S_RDYW = 3'h7
   } fws_st_type;
   typedef struct packed {
      fws_st_type st;
      fws_op_type op;
      logic [2:0] idx;
      logic [CW-1:0] cnt;
      logic [CW-1:0] tmo;
      logic req;
      logic [1:0] cfg;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] prev;
      logic tog_busy;
      logic tog_susp;
      logic raised;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [31:0] prdata;
   } fws_host_state_type;
   fws_host_state_type q_r, q_nxt;
   fws_cyc_if #(.AW(ADDR_W), .DW(DATA_W)) cyc ();
   // ------------------------------------------------------------
   // Command sequence helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] seq_len(fws_op_type op, logic short_en);
      unique case (op)
         OP_PROG: seq_len = short_en ? PROG_SHORT_LEN : PROG_LONG_LEN;
         OP_ERASE: seq_len = ERASE_LEN;
         default: seq_len = 3'h1;
      endcase
   endfunction
   function automatic logic [AD-1:0] pair(logic [11:0] a, logic [7:0] d);
      pair = {ADDR_W'(a), DATA_W'(d)};
   endfunction
   function automatic logic [AD-1:0] seq_word(fws_op_type op,
         logic short_en, logic [2:0] idx, logic [ADDR_W-1:0] a,
         logic [DATA_W-1:0] d);
      logic [ADDR_W-1:0] pa;
      pa = a;
      seq_word = {a, d};
      if (op == OP_PROT || op == OP_UNPROT) begin
         pa[ADR_SIX_BIT] = (op == OP_UNPROT); // see R5 see R6
         pa[ADR_ONE_BIT] = 1'b1; // see R5 see R6
         pa[ADR_ZERO_BIT] = 1'b0; // see R5 see R6
         seq_word = {pa, d};
      end else if (op == OP_PROG && short_en) begin
         if (idx == 3'h0) seq_word = pair(UNLOCK_ADDR1, CMD_PROGRAM);
      end else if (op == OP_PROG || op == OP_ERASE) begin
         // Full unlock pair, command, then erase repeats the unlock;
         // status reads fall back to idx 0 and so go out at UNLOCK_ADDR1
         unique case (idx)
            3'h0, 3'h3: seq_word = (op == OP_ERASE) ?
               pair(UNLOCK_ADDR1, UNLOCK_DATA1) : {a, d};
            3'h1, 3'h4: seq_word = pair(UNLOCK_ADDR2, UNLOCK_DATA2);
            3'h2: seq_word = pair(UNLOCK_ADDR1,
               (op == OP_ERASE) ? CMD_ERASE : CMD_PROGRAM);
            3'h5: seq_word = {a, DATA_W'(CMD_SECTOR)};
            default: seq_word = {a, d};
         endcase
         if (idx == 3'h0 && op == OP_PROG) begin
            seq_word = pair(UNLOCK_ADDR1, UNLOCK_DATA1);
         end
      end
   endfunction
   function automatic logic known(logic [7:0] a);
      known = (a[1:0] == 2'b00) && (a <= REG_IRQ_MASK);
   endfunction
   // ------------------------------------------------------------
   // Sequencer and register file
   // ------------------------------------------------------------
   // Event bits are OR-ed in last so a set beats a same-cycle clear
   always_comb begin
      logic ev_done;
      logic ev_tmo;
      logic last;
      ev_done = 1'b0;
      ev_tmo = 1'b0;
      last = 1'b0;
      q_nxt = q_r;
      q_nxt.req = 1'b0;
      if (q_r.st == S_POLL || q_r.st == S_POLLW || q_r.st == S_RDYW) begin
         q_nxt.tmo = q_r.tmo + 1'b1;
      end
      unique case (q_r.st)
         S_IDLE: ;
         S_SEQ: begin
            q_nxt.req = 1'b1;
            q_nxt.st = S_SEQW;
         end
         S_SEQW: if (cyc.done) begin
            last = (q_r.idx + 3'h1 == seq_len(q_r.op, q_r.cfg[0]));
            q_nxt.idx = last ? 3'h0 : q_r.idx + 3'h1; // see R8
            q_nxt.cnt = '0;
            q_nxt.st = last ? S_BUSY : S_SEQ;
         end
         S_BUSY: begin
            // Status is not trusted until T_BUSY_CYC cycles have passed for the busy output to fall
            q_nxt.cnt = q_r.cnt + 1'b1;
            if (q_r.cnt + 1'b1 >= CW'(T_BUSY_CYC)) begin // see R10
               q_nxt.cnt = '0;
               q_nxt.st = (q_r.op == OP_PROG || q_r.op == OP_ERASE) ?
                  S_POLL : S_RDYW;
            end
         end
         S_POLL: begin
            q_nxt.req = 1'b1;
            q_nxt.st = S_POLLW;
         end
         S_POLLW: if (cyc.done) begin
            q_nxt.rdata = cyc.rdata;
            q_nxt.st = S_POLL;
            if (q_r.op == OP_READ) begin
               ev_done = 1'b1;
            end else if (q_r.op == OP_TOGGLE) begin
               q_nxt.prev = cyc.rdata;
               q_nxt.idx = 3'h1;
               if (q_r.idx != 3'h0) begin
                  // Busy toggle is read at any address; see R3 see R11
                  q_nxt.tog_busy = q_r.prev[BUSY_TOG_BIT] ^
                     cyc.rdata[BUSY_TOG_BIT];
                  q_nxt.tog_susp = q_r.prev[SUSP_TOG_BIT] ^
                     cyc.rdata[SUSP_TOG_BIT]; // see R1
                  ev_done = 1'b1;
               end
            end else if (cyc.rdata[POLL_BIT] == ((q_r.op == OP_ERASE) |
                  q_r.data[POLL_BIT])) begin // see R4 see R7
               ev_done = 1'b1;
            end else if (q_r.tmo >= CW'(POLL_LIMIT)) begin
               ev_tmo = 1'b1;
            end
         end
         S_RAISE: begin
            q_nxt.cnt = q_r.cnt + 1'b1;
            ev_done = (q_r.cnt + 1'b1 >= CW'(T_RSP_CYC));
         end
         S_RDYW: begin
            // Count only an unbroken stretch of ready
            q_nxt.cnt = ready_busy_n_in ? q_r.cnt + 1'b1 : '0;
            if (ready_busy_n_in && q_r.cnt + 1'b1 >=
                  ((q_r.op == OP_TUNP_EXIT) ? CW'(T_RRB_CYC) : CW'(1))) begin
               ev_done = 1'b1;
               if (q_r.op == OP_TUNP_EXIT) q_nxt.raised = 1'b0; // see R9
            end else if (q_r.tmo >= CW'(POLL_LIMIT)) begin
               ev_tmo = 1'b1;
            end
         end
      endcase
      if (ev_done || ev_tmo) begin
         q_nxt.st = S_IDLE;
         q_nxt.idx = 3'h0;
      end
      // Register reads are captured in the setup phase
      if (psel_in && !penable_in) begin
         unique case (paddr_in)
            REG_CFG: q_nxt.prdata = 32'(q_r.cfg);
            REG_ADDR: q_nxt.prdata = 32'(q_r.addr);
            REG_DATA: q_nxt.prdata = 32'(q_r.data);
            REG_STAT: q_nxt.prdata = 32'({ready_busy_n_in, q_r.tog_susp,
               q_r.tog_busy, q_r.raised, q_r.st != S_IDLE});
            REG_RDATA: q_nxt.prdata = 32'(q_r.rdata);
            REG_IRQ_STAT: q_nxt.prdata = 32'(q_r.irq_stat);
            REG_IRQ_MASK: q_nxt.prdata = 32'(q_r.irq_mask);
            default: q_nxt.prdata = 32'h0;
         endcase
      end
      if (psel_in && penable_in && pwrite_in) begin
         unique case (paddr_in)
            REG_CMD: if (q_r.st == S_IDLE) begin
               q_nxt.op = fws_op_type'(pwdata_in[2:0]);
               q_nxt.tmo = '0;
               q_nxt.cnt = '0;
               unique case (fws_op_type'(pwdata_in[2:0]))
                  OP_READ, OP_TOGGLE: q_nxt.st = S_POLL;
                  OP_TUNP_ENTER: begin
                     q_nxt.raised = 1'b1;
                     q_nxt.st = S_RAISE;
                  end
                  OP_TUNP_EXIT: q_nxt.st = S_RDYW;
                  default: q_nxt.st = S_SEQ;
               endcase
            end
            REG_CFG: q_nxt.cfg = pwdata_in[1:0];
            REG_ADDR: q_nxt.addr = pwdata_in[ADDR_W-1:0];
            REG_DATA: q_nxt.data = pwdata_in[DATA_W-1:0];
            REG_IRQ_STAT: q_nxt.irq_stat = q_r.irq_stat & ~pwdata_in[1:0];
            REG_IRQ_MASK: q_nxt.irq_mask = pwdata_in[1:0];
            default: ;
         endcase
      end
      q_nxt.irq_stat[IRQ_DONE_BIT] = q_nxt.irq_stat[IRQ_DONE_BIT] | ev_done;
      q_nxt.irq_stat[IRQ_TMO_BIT] = q_nxt.irq_stat[IRQ_TMO_BIT] | ev_tmo;
   end
   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         q_r <= '{st: S_IDLE, op: OP_READ, cfg: CFG_RST,
                  irq_mask: IRQ_MASK_RST, default: '0};
      end else begin
         q_r <= q_nxt;
      end
   end
   // ------------------------------------------------------------
   // Cycle engine and outputs
   // ------------------------------------------------------------
   assign cyc.req = q_r.req;
   assign cyc.wr = (q_r.st == S_SEQ || q_r.st == S_SEQW);
   assign cyc.hold = (q_r.st == S_POLL || q_r.st == S_POLLW) &&
      (q_r.op != OP_READ);
   assign cyc.strobe_ce = q_r.cfg[CFG_CE_STROBE_BIT]; // see R2
   assign {cyc.addr, cyc.wdata} = seq_word(q_r.op, q_r.cfg[CFG_SHORT_BIT],
      q_r.idx, q_r.addr, q_r.data);
   fws_bus_cycle #(.AW(ADDR_W), .DW(DATA_W)) u_cycle (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .cyc(cyc.engine),
      .flash_ce_n_out(flash_ce_n_out),
      .flash_oe_n_out(flash_oe_n_out),
      .flash_we_n_out(flash_we_n_out),
      .flash_addr_out(flash_addr_out),
      .flash_dq_out(flash_dq_out),
      .flash_dq_oe_out(flash_dq_oe_out),
      .flash_dq_in(flash_dq_in)
   );
   assign prdata_out = q_r.prdata;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !known(paddr_in);
   assign irq_out = |(q_r.irq_stat & q_r.irq_mask);
   assign raised_pin_level_out = q_r.raised;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [3:0] wfall_r;
   logic [7:0] rb_hi_r;
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || q_r.st == S_IDLE) begin
         wfall_r <= 4'h0;
      end else if (!flash_we_n_out && $past(flash_we_n_out)) begin
         wfall_r <= wfall_r + 4'h1;
      end
      if (!rst_n_in || !(q_r.raised && ready_busy_n_in)) begin
         rb_hi_r <= 8'h0;
      end else if (rb_hi_r != 8'hff) begin
         rb_hi_r <= rb_hi_r + 8'h1;
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   strobe_hold_a: assert property (cyc.hold && !flash_ce_n_out |-> // see R2
      (cyc.strobe_ce ? !flash_oe_n_out : 1'b1)
      ##1 (cyc.hold && !cyc.strobe_ce) |-> !flash_ce_n_out)
      else $error("held strobe released during polling");
   prot_addr_a: assert property (q_r.op == OP_PROT && // see R5
      !flash_we_n_out |-> !flash_addr_out[6] && flash_addr_out[1] &&
      !flash_addr_out[0]) else $error("protect address bits wrong");
   unprot_addr_a: assert property (q_r.op == OP_UNPROT && // see R6
      !flash_we_n_out |-> flash_addr_out[6] && flash_addr_out[1] &&
      !flash_addr_out[0]) else $error("unprotect address bits wrong");
   prog_len_a: assert property ($rose(q_r.st == S_BUSY) && // see R8
      q_r.op == OP_PROG |-> wfall_r == 4'h2 || wfall_r == 4'h4)
      else $error("program command length not two or four");
   lower_hold_a: assert property ($fell(raised_pin_level_out) |-> // see R9
      $past(rb_hi_r) >= 8'(T_RRB_CYC) - 8'h1)
      else $error("raised level dropped too soon after ready");
   busy_wait_a: assert property ($rose(q_r.st == S_BUSY) |-> // see R10
      flash_we_n_out ##1 q_r.st != S_SEQ)
      else $error("status read before busy settled");
   prog_done_c: cover property (q_r.op == OP_PROG && $fell(cyc.hold));
   erase_done_c: cover property (q_r.op == OP_ERASE && $fell(cyc.hold));
   toggle_c: cover property (q_r.op == OP_TOGGLE && $rose(q_r.tog_busy));
   tunp_exit_c: cover property ($fell(raised_pin_level_out));
endmodule

// >>> fws_pkg.sv
// Shared constants and types of the flash status and protect host
package fws_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 10;
   localparam int T_BUSY_NS = 90;
   localparam int T_BUSY_RAW = T_BUSY_NS * CLK_MHZ / 1000;
   localparam int T_BUSY_CYC = (T_BUSY_RAW < 1) ? 1 : T_BUSY_RAW;
   localparam int T_RSP_US = 4;
   localparam int T_RSP_CYC = T_RSP_US * CLK_MHZ;
   localparam int T_RRB_US = 4;
   localparam int T_RRB_CYC = T_RRB_US * CLK_MHZ;
   localparam int ERASE_MAX_MS = 5000;
   localparam int POLL_MAX_CYC = ERASE_MAX_MS * CLK_MHZ * 1000;
   // ------------------------------------------------------------
   // Flash bus shape and status bits
   // ------------------------------------------------------------
   localparam int FL_ADDR_W = 23;
   localparam int FL_DATA_W = 16;
   localparam int POLL_BIT = 7;
   localparam int BUSY_TOG_BIT = 6;
   localparam int SUSP_TOG_BIT = 2;
   localparam int ADR_SIX_BIT = 6;
   localparam int ADR_ONE_BIT = 1;
   localparam int ADR_ZERO_BIT = 0;
   localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
   localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
   localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
   localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_SECTOR = 8'h30;
   localparam logic [2:0] PROG_LONG_LEN = 3'h4;
   localparam logic [2:0] PROG_SHORT_LEN = 3'h2;
   localparam logic [2:0] ERASE_LEN = 3'h6;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_DATA = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_RDATA = 8'h14;
   localparam logic [7:0] REG_IRQ_STAT = 8'h18;
   localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
   localparam int CFG_SHORT_BIT = 0;
   localparam int CFG_CE_STROBE_BIT = 1;
   localparam logic [1:0] CFG_RST = 2'h0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_TMO_BIT = 1;
   typedef enum logic [2:0] {
      OP_READ = 3'h0, OP_PROG = 3'h1, OP_ERASE = 3'h2, OP_TOGGLE = 3'h3,
      OP_PROT = 3'h4, OP_UNPROT = 3'h5, OP_TUNP_ENTER = 3'h6,
      OP_TUNP_EXIT = 3'h7
   } fws_op_type;
endpackage

// >>> tb_flash_write_status_protect.sv
// Self-checking bench for the flash status and protect host
`timescale 1ns/1ps
module tb_flash_write_status_protect import fws_pkg::*;;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic ce_n, oe_n, we_n, fdq_oe, rb_n, raised, stuck;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [22:0] fa;
   logic [15:0] fdq_o, fdq_i;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int n0;
   fws_host #(.POLL_LIMIT(200)) dut_u (.core_clk_in(clk), .rst_n_in(rst_n),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
      .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
      .flash_addr_out(fa), .flash_dq_out(fdq_o), .flash_dq_oe_out(fdq_oe),
      .flash_dq_in(fdq_i), .ready_busy_n_in(rb_n),
      .raised_pin_level_out(raised));
   fws_flash_model fl_u (.clk_in(clk), .stuck_in(stuck), .ce_n_in(ce_n),
      .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(fa), .dq_in(fdq_o),
      .dq_oe_in(fdq_oe), .dq_out(fdq_i), .ready_busy_n_out(rb_n));
   // ------------------------------------------------------------
   // Clock, watchdog and access tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // A hang counts as a mismatch and ends the run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; an idle cycle follows so no strobe is set twice
   task automatic apb(input logic [7:0] a, input logic w,
         input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Start an operation, then poll the busy flag with a bound
   task automatic op(input logic [2:0] c, input logic dup);
      int i;
      apb(REG_CMD, 1'b1, {29'h0, c});
      if (dup) apb(REG_CMD, 1'b1, 32'h2);
      i = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && i < 1000) begin
         apb(REG_STAT, 1'b0, 32'h0);
         i++;
      end
      check(32'(i < 1000), 32'h1);
   endtask
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, stuck, err} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(REG_CFG, 1'b0, 32'h0);
      check(q, 32'h0);
      apb(REG_IRQ_MASK, 1'b0, 32'h0);
      check(q, 32'h0);
      apb(8'h20, 1'b0, 32'h0);
      check({q[30:0], err}, 32'h1);
      // Long program, with a second command refused while busy
      apb(REG_ADDR, 1'b1, 32'h12);
      apb(REG_DATA, 1'b1, 32'h5a3c);
      n0 = fl_u.n_wr;
      op(OP_PROG, 1'b1);
      check(32'(fl_u.n_wr - n0), 32'h4);
      check({16'h0, fl_u.mem[8'h12]}, 32'h5a3c);
      check({31'h0, irq}, 32'h0);
      apb(REG_IRQ_MASK, 1'b1, 32'h3);
      check({31'h0, irq}, 32'h1);
      apb(REG_IRQ_STAT, 1'b1, 32'h1);
      check({31'h0, irq}, 32'h0);
      op(OP_READ, 1'b0);
      apb(REG_RDATA, 1'b0, 32'h0);
      check(q, 32'h5a3c);
      // Short program strobed through chip select
      apb(REG_CFG, 1'b1, 32'h3);
      apb(REG_ADDR, 1'b1, 32'h13);
      apb(REG_DATA, 1'b1, 32'h81);
      n0 = fl_u.n_wr;
      op(OP_PROG, 1'b0);
      check(32'(fl_u.n_wr - n0), 32'h2);
      check({16'h0, fl_u.mem[8'h13]}, 32'h81);
      apb(REG_CFG, 1'b1, 32'h0);
      n0 = fl_u.n_wr;
      op(OP_ERASE, 1'b0);
      check(32'(fl_u.n_wr - n0), 32'h6);
      check({15'h0, fl_u.pre_done, fl_u.mem[8'h12]}, 32'h1ffff);
      // Toggle checks in and out of the suspended sector, both strobes
      for (int k = 0; k < 2; k++) begin
         apb(REG_CFG, 1'b1, 32'(2 * k));
         apb(REG_ADDR, 1'b1, 32'h28000);
         op(OP_TOGGLE, 1'b0);
         check({30'h0, q[3:2]}, 32'h2);
         apb(REG_ADDR, 1'b1, 32'h12);
         op(OP_TOGGLE, 1'b0);
         check({30'h0, q[3:2]}, 32'h0);
      end
      apb(REG_CFG, 1'b1, 32'h0);
      apb(REG_ADDR, 1'b1, 32'h100);
      for (int c = 4; c < 6; c++) begin
         op(3'(c), 1'b0);
         check(32'(fl_u.last_a & 23'h43), c == 5 ? 32'h42 : 32'h2);
      end
      op(OP_TUNP_ENTER, 1'b0);
      check({30'h0, q[1], raised}, 32'h3);
      n0 = cyc;
      op(OP_TUNP_EXIT, 1'b0);
      check(32'(cyc - n0 > T_RRB_CYC), 32'h1);
      check({31'h0, raised}, 32'h0);
      // A device that never finishes must end in a timeout
      apb(REG_IRQ_STAT, 1'b1, 32'h3);
      stuck <= 1'b1;
      op(OP_PROG, 1'b0);
      apb(REG_IRQ_STAT, 1'b0, 32'h0);
      check({31'h0, q[IRQ_TMO_BIT]}, 32'h1);
      // A busy device toggles its busy bit on every read, at any address
      op(OP_TOGGLE, 1'b0);
      check({30'h0, q[3:2]}, 32'h1);
      stuck <= 1'b0;
      print_verdict();
   end
endmodule
